// ==== msr_master_status.sv ====
/*
 upper byte of the master status and terminal reset register, with ready
 generation and host access gating.
 assumes rst is the master reset pin, active high; auto-init, self-test and
 controller status come from logic on sys_clk; strap comes from a pin.
*/
`timescale 1ns/1ps
module msr_master_status (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pins
	input wire logic auto_init_strap,
	output logic ready_pin,
	// host register port
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_addr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	output logic host_access_en,
	// device status
	input wire logic auto_init_busy,
	input wire logic self_test_busy,
	input wire logic controller_msg_in_progress,
	input wire logic controller_running,
	// terminal soft reset
	output logic terminal_start_execution_clr,
	output logic terminal_reset_start,
	input wire logic terminal_reset_done,
	// low status byte from elsewhere
	input wire logic [7:0] status_low
);
	logic strap_sync;
	logic strap_q;
	logic strap_taken_q;
	logic [1:0] strap_settle_q;
	logic start_q;
	logic req_q;
	logic ready_q;
	logic mip_q;
	logic run_q;
	logic [15:0] reg_val;
	msr_pkg::msr_state_t state_q;
	msr_pkg::msr_state_t state_d;

	msr_sync u_strap_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(auto_init_strap),
		.sync_out(strap_sync)
	);

	function automatic logic addr_is_status(input logic [15:0] a);
		addr_is_status = (a == msr_pkg::MSR_ADDR_STATUS);
	endfunction : addr_is_status

	function automatic logic wr_hit(input logic wr, input logic [15:0] a);
		wr_hit = wr && addr_is_status(a);
	endfunction : wr_hit

	// the synchroniser needs two edges to fill after release
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strap_settle_q <= 2'h0;
		end else begin
			strap_settle_q <= {strap_settle_q[0], 1'b1};
		end
	end

	// strap caught once after release; async reset may only load a constant
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strap_q <= 1'b0;
			strap_taken_q <= 1'b0;
		end else if (strap_settle_q[1] && !strap_taken_q) begin
			strap_q <= strap_sync;
			strap_taken_q <= 1'b1;
		end
	end

	// soft reset sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			msr_pkg::MSR_IDLE: begin
				if (ready_q && wr_hit(host_wr, host_addr)
						&& host_wdata[msr_pkg::MSR_BIT_RESET_REQ]) begin
					state_d = msr_pkg::MSR_CLEAR_START;
				end
			end
			msr_pkg::MSR_CLEAR_START: state_d = msr_pkg::MSR_ACTIONS;
			msr_pkg::MSR_ACTIONS: begin
				if (terminal_reset_done) begin
					state_d = msr_pkg::MSR_IDLE;
				end
			end
			default: state_d = msr_pkg::MSR_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= msr_pkg::MSR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			req_q <= 1'b0;
		end else begin
			req_q <= (state_d != msr_pkg::MSR_IDLE);
		end
	end

	// actions start one cycle after the start-execution clear, never with it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_q <= 1'b0;
		end else begin
			start_q <= (state_q == msr_pkg::MSR_CLEAR_START);
		end
	end

	assign terminal_start_execution_clr = (state_q == msr_pkg::MSR_CLEAR_START);
	assign terminal_reset_start = start_q;

	// ready: low while any initialisation activity runs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= !(auto_init_busy || self_test_busy
				|| (state_d != msr_pkg::MSR_IDLE));
		end
	end

	// mip mirrored, run set while running or mip; source drops mip only after buffer updates
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mip_q <= 1'b0;
		end else begin
			mip_q <= controller_msg_in_progress;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
		end else begin
			run_q <= controller_running || controller_msg_in_progress;
		end
	end

	// contents never touched by soft reset; writes to read-only bits dropped
	always_comb begin
		reg_val = msr_pkg::MSR_RESET_VAL;
		reg_val[msr_pkg::MSR_BIT_READY] = ready_q;
		reg_val[msr_pkg::MSR_BIT_STRAP] = strap_q;
		reg_val[msr_pkg::MSR_BIT_RESET_REQ] = req_q;
		reg_val[msr_pkg::MSR_BIT_MIP] = mip_q;
		reg_val[msr_pkg::MSR_BIT_RUN] = run_q;
		reg_val[7:0] = status_low;
	end

	assign ready_pin = ready_q;
	assign host_access_en = ready_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_rdata <= msr_pkg::MSR_RESET_VAL;
		end else if (host_rd) begin
			if (!ready_q || addr_is_status(host_addr)) begin
				host_rdata <= reg_val;
			end else begin
				host_rdata <= msr_pkg::MSR_RESET_VAL;
			end
		end
	end
endmodule : msr_master_status

// ==== msr_master_status_tb.sv ====
/* testbench: host reads and writes with expected words
 assumes msr_props and msr_rst_model */
`timescale 1ns/1ps
module msr_master_status_tb;
	logic sys_clk = 0, rst = 1, strap = 1, rd = 0, wr = 0, aib = 0, stb = 0, mip = 0, run = 0;
	logic [15:0] addr = 16'h0, wd = 16'h0, rdata;
	logic ready, en, clr, start, done;
	int fail_count = 0, n_checks = 0;
	always #5 sys_clk = ~sys_clk;
	msr_master_status dut_u (.sys_clk, .rst, .auto_init_strap(strap), .ready_pin(ready),
		.host_rd(rd), .host_wr(wr), .host_addr(addr), .host_wdata(wd), .host_rdata(rdata),
		.host_access_en(en), .auto_init_busy(aib), .self_test_busy(stb),
		.controller_msg_in_progress(mip), .controller_running(run),
		.terminal_start_execution_clr(clr), .terminal_reset_start(start),
		.terminal_reset_done(done), .status_low(8'h5a));
	msr_rst_model m_u (.sys_clk, .rst, .start, .done);
	task automatic wr_reg(input logic [15:0] a, d);
		@(posedge sys_clk) begin addr <= a; wd <= d; wr <= 1'b1; end
		@(posedge sys_clk) wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [15:0] a, e);
		@(posedge sys_clk) begin addr <= a; rd <= 1'b1; end
		@(posedge sys_clk) rd <= 1'b0;
		#1 n_checks++;
		if (rdata !== e) begin fail_count++; $display("[FAIL] %0t %h %h", $time, rdata, e); end
	endtask : rd_chk
	task automatic print_verdict;
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd_chk(16'h0001, 16'ha05a);
		wr_reg(16'h0001, 16'hffff);
		rd_chk(16'h0123, 16'h245a);
		for (int i = 0; i < 50 && ready !== 1'b1; i++) @(posedge sys_clk);
		rd_chk(16'h0001, 16'ha05a);
		@(posedge sys_clk) begin run <= 1'b1; mip <= 1'b1; end
		wr_reg(16'h0001, 16'hfbff);
		rd_chk(16'h0001, 16'ha35a);
		@(posedge sys_clk) mip <= 1'b0;
		rd_chk(16'h0001, 16'ha15a);
		@(posedge sys_clk) begin aib <= 1'b1; run <= 1'b0; end
		rd_chk(16'h0002, 16'h205a);
		wr_reg(16'h0001, 16'h0400);
		rd_chk(16'h0001, 16'h205a);
		@(posedge sys_clk) begin aib <= 1'b0; strap <= 1'b0; rst <= 1'b1; end
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd_chk(16'h0001, 16'h805a);
		print_verdict;
	end
	// whole run is under a hundred cycles
	initial begin #5000; fail_count++; print_verdict; end
endmodule : msr_master_status_tb
bind msr_master_status msr_props chk_u (.sys_clk, .rst, .ready_pin, .host_access_en,
	.auto_init_busy, .self_test_busy, .controller_running, .terminal_reset_done, .host_rd,
	.host_wr, .host_addr, .host_wdata, .host_rdata, .status_low, .terminal_start_execution_clr,
	.terminal_reset_start);

// ==== msr_pkg.sv ====
/*
 master status and terminal reset register: shared constants.
 assumes a host port decoder that presents word-wide register accesses.
*/
package msr_pkg;
	localparam logic [15:0] MSR_ADDR_CONFIG = 16'h0000;
	localparam logic [15:0] MSR_ADDR_STATUS = 16'h0001;
	localparam logic [15:0] MSR_RESET_VAL = 16'h0000;
	localparam int MSR_BIT_READY = 15;
	localparam int MSR_BIT_STRAP = 13;
	localparam int MSR_BIT_RESET_REQ = 10;
	localparam int MSR_BIT_MIP = 9;
	localparam int MSR_BIT_RUN = 8;
	localparam int MSR_BIT_START_EXEC = 4;
	typedef enum logic [1:0] {
		MSR_IDLE = 2'b00,
		MSR_CLEAR_START = 2'b01,
		MSR_ACTIONS = 2'b10
	} msr_state_t;
endpackage : msr_pkg

// ==== msr_properties.sv ====
/* status register checker
 sees only the top ports */
`timescale 1ns/1ps
module msr_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pins and status
	input wire logic ready_pin,
	input wire logic host_access_en,
	input wire logic auto_init_busy,
	input wire logic self_test_busy,
	input wire logic controller_running,
	input wire logic terminal_reset_done,
	// host port
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	input wire logic [7:0] status_low,
	// reset outputs
	input wire logic terminal_start_execution_clr,
	input wire logic terminal_reset_start
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_en; ready_pin == host_access_en; endproperty
	a_en: assert property (p_en) else $error("gate");
	property p_clr; terminal_start_execution_clr |=> terminal_reset_start; endproperty
	a_clr: assert property (p_clr) else $error("order");
	property p_wr; host_wr && ready_pin && host_addr == 16'h0001 && host_wdata[10]
		|=> !ready_pin && terminal_start_execution_clr; endproperty
	a_wr: assert property (p_wr) else $error("start");
	property p_done; terminal_reset_done && !auto_init_busy && !self_test_busy |=> ready_pin;
	endproperty
	a_done: assert property (p_done) else $error("done");
	property p_busy; auto_init_busy || self_test_busy |=> !ready_pin; endproperty
	a_busy: assert property (p_busy) else $error("busy");
	property p_zero; host_rd |=> host_rdata[14] == 1'b0 && host_rdata[12:11] == 2'h0; endproperty
	a_zero: assert property (p_zero) else $error("unused");
	property p_any; host_rd && !ready_pin |=> host_rdata[7:0] == $past(status_low) && !host_rdata[15];
	endproperty
	a_any: assert property (p_any) else $error("any");
	// steady for two edges so the register lag cannot matter
	property p_run; host_rd && host_addr == 16'h0001 && controller_running
		&& $past(controller_running) |=> host_rdata[8]; endproperty
	a_run: assert property (p_run) else $error("run");
	c_wr: cover property (host_wr && host_wdata[10]);
	c_any: cover property (host_rd && !ready_pin);
	c_done: cover property (terminal_reset_done);
endmodule : msr_props

// ==== msr_rst_model.sv ====
/* terminal reset actions model
 answers a start pulse with a done pulse after a delay
 assumes start is a one-cycle pulse on sys_clk */
`timescale 1ns/1ps
module msr_rst_model #(parameter int DLY = 12) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// handshake with the design
	input wire logic start,
	output logic done
);
	int n;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			n <= 0;
			done <= 1'b0;
		end else begin
			done <= (n == 1);
			n <= start ? DLY : (n > 0 ? n - 1 : 0);
		end
	end
endmodule : msr_rst_model

// ==== msr_sync.sv ====
/*
 two-flop synchroniser for asynchronous pin levels.
 assumes the destination clock is sys_clk.
*/
`timescale 1ns/1ps
module msr_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// level
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : msr_sync
